/* File: ficu_pkg.sv */
/*
  ficu_pkg: constants and types shared by the flash command unit.
  Assumes nothing of its surroundings; holds definitions only.
*/
package ficu_pkg;

  // feed sequence keys
  localparam logic [7:0] FEED_FIRST_KEY = 8'hA2;
  localparam logic [7:0] FEED_PART0_KEY = 8'hDF;
  localparam logic [7:0] FEED_PART1_KEY = 8'hFD;

  // command codes, low seven bits of the command byte
  localparam logic [6:0] CMD_CHIP_ERASE = 7'h01;
  localparam logic [6:0] CMD_PAGE_SECURE = 7'h03;
  localparam logic [6:0] CMD_CHIP_SECURE = 7'h05;
  localparam logic [6:0] CMD_BOOT_OPTION = 7'h08;
  localparam logic [6:0] CMD_SET_VECTOR = 7'h09;
  localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0B;
  localparam logic [6:0] CMD_BYTE_VERIFY = 7'h0C;
  localparam logic [6:0] CMD_PART0_ERASE = 7'h0D;
  localparam logic [6:0] CMD_BYTE_PROGRAM = 7'h0E;

  // selector bytes carried in the address-high register
  localparam logic [7:0] SEL_PAGE_BASE = 8'h90;
  localparam logic [7:0] SEL_PAGE_LAST = 8'h94;
  localparam logic [7:0] SEL_CHIP_BASE = 8'hB0;
  localparam logic [7:0] SEL_CHIP_LAST = 8'hB3;
  localparam logic [7:0] SEL_CLOCK_DOUBLE = 8'hE0;
  localparam logic [7:0] SEL_USER_VECTOR = 8'hE1;
  localparam logic [7:0] SEL_FROM_ZERO = 8'hE2;
  localparam logic [7:0] SEL_VECTOR = 8'hF0;

  // array geometry
  localparam int SECTOR_BYTES = 128;
  localparam int PAGE_COUNT = 5;
  localparam int CHIP_SEC_COUNT = 4;
  localparam logic [2:0] LOADER_PAGE = 3'h4;

  // boot addresses and factory values
  localparam logic [15:0] DEFAULT_BOOT_PC = 16'hF800;
  localparam logic [15:0] ZERO_BOOT_PC = 16'h0000;
  localparam logic [7:0] BOOT_PC_LOW = 8'h00;
  localparam logic [7:0] FACTORY_VECTOR = 8'hF8;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;

  // machine cycle lengths in oscillator clocks
  localparam logic [3:0] CLKS_STANDARD = 4'hC;
  localparam logic [3:0] CLKS_DOUBLED = 4'h6;

  // operations handed to the flash array
  typedef enum logic [2:0] {
    FICU_OP_NONE = 3'h0,
    FICU_OP_CHIP_ERASE = 3'h1,
    FICU_OP_PART_ERASE = 3'h2,
    FICU_OP_SECTOR_ERASE = 3'h3,
    FICU_OP_PROGRAM = 3'h4,
    FICU_OP_READ = 3'h5
  } ficu_op_e;

  // sequencer states, gray along idle-fed-armed-busy
  typedef enum logic [1:0] {
    FICU_IDLE = 2'b00,
    FICU_FED = 2'b01,
    FICU_ARMED = 2'b11,
    FICU_BUSY = 2'b10
  } ficu_state_e;

endpackage

/* File: ficu_sync.sv */
/*
  ficu_sync: two-flop synchroniser for pin levels.
  Assumes inputs are asynchronous levels; output is two edges late.
*/
`timescale 1ns/1ps
`default_nettype none
module ficu_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule
`default_nettype wire

/* File: ficu_top.sv */
/*
  ficu_top: in-application flash command sequencer with boot selection.
  Assumes same-clock strobes from the CPU register file, a flash array
  that answers each start with one done pulse, and asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - commands taken only in in-app mode; command byte write starts operation
// - command writes without completed feed sequence are refused
// - codes: 01 chip, 0D part0, 0B sector, 0E program, 0C verify, 03, 05, 08, 09
// - CPU held stalled from command start until the command finishes
// - sector erase, program, verify refused on a security-locked page
// - chip erase performed only when external-access pin is low
// - chip erase clears all security and boot vector; boot then F800
// - partition-0 erase erases partition 0 and unlocks pages 0 to 3
// - sector erase removes the 128-byte sector at address high/low
// - byte program writes data register into addressed byte
// - byte verify returns the addressed byte into the data register
// - secure-page commands lock pages 0 to 4, effective at completion
// - page bits read 1 unlocked; commands only lock; chip and partition-0 erase unlock, sector erase does not
// - clock double selects 6 clocks per machine cycle, default 12
// - loader access bit resets to 1 only with boot-from-zero bit 1 or strap entry with external-access pin high
// - boot-from-zero 0 starts execution at 0000
// - both boot bits 1 starts at default vector F800
// - boot-from-zero 1, user-vector 0 starts at stored vector, low 00
// - both straps low at reset start from boot vector, ignoring jumper
// - boot status records whether last boot came from strap entry
module ficu_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic IAP_MODE,
  input wire logic FEED_FIRST_WR,
  input wire logic FEED_SECOND_WR,
  input wire logic CMD_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] FLASH_ADDR_HIGH,
  input wire logic [7:0] FLASH_ADDR_LOW,
  input wire logic [7:0] FLASH_DATA_IN,
  input wire logic EXTERNAL_ACCESS_N,
  input wire logic BOOT_STRAP_PIN_A,
  input wire logic BOOT_STRAP_PIN_B,
  input wire logic LOADER_EN_WR,
  input wire logic LOADER_EN_WDATA,
  input wire logic ARRAY_DONE,
  input wire logic [7:0] ARRAY_RDATA,
  output logic ARRAY_START,
  output logic [2:0] ARRAY_OP,
  output logic ARRAY_PART,
  output logic [14:0] ARRAY_ADDR,
  output logic [7:0] ARRAY_WDATA,
  output logic CPU_HOLD,
  output logic CMD_DONE,
  output logic CMD_REFUSED,
  output logic [7:0] FLASH_DATA_OUT,
  output logic FLASH_DATA_LOAD,
  output logic [4:0] PAGE_UNLOCKED,
  output logic [3:0] CHIP_SECURITY,
  output logic CLOCK_DOUBLE,
  output logic [3:0] CLKS_PER_CYCLE,
  output logic [15:0] BOOT_PC,
  output logic BOOT_VALID,
  output logic LOADER_ACCESS_EN,
  output logic HW_ENTRY_BOOT
);

  ficu_pkg::ficu_state_e state_reg;
  logic part_reg;
  logic [6:0] cmd_reg;
  logic [7:0] sel_reg;
  logic [7:0] data_reg;
  logic wait_reg;
  logic from_zero_reg;
  logic user_vec_n_reg;
  logic [7:0] vector_reg;
  logic [1:0] settle_reg;
  logic [2:0] pins_sync;
  logic ea_n_sync;
  logic strap_a_sync;
  logic strap_b_sync;
  logic [14:0] addr;
  logic [2:0] page;
  logic legal;
  ficu_pkg::ficu_op_e op;
  logic finish;

  // page index: partition 1 is the loader page, else 8 KB pages
  function automatic logic [2:0] page_of(input logic part, input logic [14:0] a);
    page_of = part ? ficu_pkg::LOADER_PAGE : {1'b0, a[14:13]};
  endfunction

  // selector range check for grouped commands
  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // pin levels cross into the clock domain
  ficu_sync #(.WIDTH(3)) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .async_in({EXTERNAL_ACCESS_N, BOOT_STRAP_PIN_A, BOOT_STRAP_PIN_B}),
    .sync_out(pins_sync)
  );

  assign ea_n_sync = pins_sync[2];
  assign strap_a_sync = pins_sync[1];
  assign strap_b_sync = pins_sync[0];
  assign addr = {FLASH_ADDR_HIGH[6:0], FLASH_ADDR_LOW};
  assign page = page_of(part_reg, addr);
  assign finish = (state_reg == ficu_pkg::FICU_BUSY) && (!wait_reg || ARRAY_DONE);

  // command legality and array operation for the byte being written
  always_comb begin
    legal = 1'b0;
    op = ficu_pkg::FICU_OP_NONE;
    unique case (SFR_WDATA[6:0])
      ficu_pkg::CMD_CHIP_ERASE: begin
        legal = !ea_n_sync;
        op = ficu_pkg::FICU_OP_CHIP_ERASE;
      end
      ficu_pkg::CMD_PART0_ERASE: begin
        legal = 1'b1;
        op = ficu_pkg::FICU_OP_PART_ERASE;
      end
      ficu_pkg::CMD_SECTOR_ERASE: begin
        legal = PAGE_UNLOCKED[page];
        op = ficu_pkg::FICU_OP_SECTOR_ERASE;
      end
      ficu_pkg::CMD_BYTE_PROGRAM: begin
        legal = PAGE_UNLOCKED[page];
        op = ficu_pkg::FICU_OP_PROGRAM;
      end
      ficu_pkg::CMD_BYTE_VERIFY: begin
        legal = PAGE_UNLOCKED[page];
        op = ficu_pkg::FICU_OP_READ;
      end
      ficu_pkg::CMD_PAGE_SECURE: begin
        legal = in_range(FLASH_ADDR_HIGH, ficu_pkg::SEL_PAGE_BASE, ficu_pkg::SEL_PAGE_LAST);
      end
      ficu_pkg::CMD_CHIP_SECURE: begin
        legal = in_range(FLASH_ADDR_HIGH, ficu_pkg::SEL_CHIP_BASE, ficu_pkg::SEL_CHIP_LAST);
      end
      ficu_pkg::CMD_BOOT_OPTION: begin
        legal = in_range(FLASH_ADDR_HIGH, ficu_pkg::SEL_CLOCK_DOUBLE,
                         ficu_pkg::SEL_FROM_ZERO);
      end
      ficu_pkg::CMD_SET_VECTOR: begin
        legal = (FLASH_ADDR_HIGH == ficu_pkg::SEL_VECTOR);
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // feed sequence and command sequencer
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ficu_pkg::FICU_IDLE;
      part_reg <= 1'b0;
      cmd_reg <= 7'h00;
      sel_reg <= 8'h00;
      data_reg <= 8'h00;
      wait_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ficu_pkg::FICU_IDLE: begin
          if (FEED_FIRST_WR && SFR_WDATA == ficu_pkg::FEED_FIRST_KEY) begin
            state_reg <= ficu_pkg::FICU_FED;
          end
        end
        ficu_pkg::FICU_FED: begin
          if (FEED_SECOND_WR) begin
            if (SFR_WDATA == ficu_pkg::FEED_PART0_KEY ||
                SFR_WDATA == ficu_pkg::FEED_PART1_KEY) begin
              state_reg <= ficu_pkg::FICU_ARMED;
              part_reg <= (SFR_WDATA == ficu_pkg::FEED_PART1_KEY);
            end else begin
              state_reg <= ficu_pkg::FICU_IDLE;
            end
          end else if (FEED_FIRST_WR || CMD_WR) begin
            state_reg <= ficu_pkg::FICU_IDLE;
          end
        end
        ficu_pkg::FICU_ARMED: begin
          if (CMD_WR) begin
            if (IAP_MODE && legal) begin
              state_reg <= ficu_pkg::FICU_BUSY;
              cmd_reg <= SFR_WDATA[6:0];
              sel_reg <= FLASH_ADDR_HIGH;
              data_reg <= FLASH_DATA_IN;
              wait_reg <= (op != ficu_pkg::FICU_OP_NONE);
            end else begin
              state_reg <= ficu_pkg::FICU_IDLE;
            end
          end else if (FEED_FIRST_WR || FEED_SECOND_WR) begin
            state_reg <= ficu_pkg::FICU_IDLE;
          end
        end
        ficu_pkg::FICU_BUSY: begin
          if (finish) begin
            state_reg <= ficu_pkg::FICU_IDLE;
            wait_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // array start, operands and cpu hold
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ARRAY_START <= 1'b0;
      ARRAY_OP <= ficu_pkg::FICU_OP_NONE;
      ARRAY_PART <= 1'b0;
      ARRAY_ADDR <= 15'h0000;
      ARRAY_WDATA <= 8'h00;
      CPU_HOLD <= 1'b0;
    end else begin
      ARRAY_START <= 1'b0;
      if (state_reg == ficu_pkg::FICU_ARMED && CMD_WR && IAP_MODE && legal) begin
        CPU_HOLD <= 1'b1;
        ARRAY_START <= (op != ficu_pkg::FICU_OP_NONE);
        ARRAY_OP <= op;
        ARRAY_PART <= part_reg;
        ARRAY_ADDR <= addr;
        ARRAY_WDATA <= FLASH_DATA_IN;
      end else if (finish) begin
        CPU_HOLD <= 1'b0;
      end
    end
  end

  // completion and refusal pulses, verify data return
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CMD_DONE <= 1'b0;
      CMD_REFUSED <= 1'b0;
      FLASH_DATA_OUT <= 8'h00;
      FLASH_DATA_LOAD <= 1'b0;
    end else begin
      CMD_DONE <= finish;
      CMD_REFUSED <= CMD_WR && (state_reg != ficu_pkg::FICU_ARMED ||
                               !IAP_MODE || !legal);
      FLASH_DATA_LOAD <= 1'b0;
      if (finish && cmd_reg == ficu_pkg::CMD_BYTE_VERIFY) begin
        FLASH_DATA_OUT <= ARRAY_RDATA;
        FLASH_DATA_LOAD <= 1'b1;
      end
    end
  end

  // security and boot option bits, factory state all ones but vector F8 and clock double 0
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAGE_UNLOCKED <= '1;
      CHIP_SECURITY <= '1;
      from_zero_reg <= 1'b1;
      user_vec_n_reg <= 1'b1;
      vector_reg <= ficu_pkg::FACTORY_VECTOR;
      CLOCK_DOUBLE <= 1'b0;
      CLKS_PER_CYCLE <= ficu_pkg::CLKS_STANDARD;
    end else begin
      CLKS_PER_CYCLE <= CLOCK_DOUBLE ? ficu_pkg::CLKS_DOUBLED
                                     : ficu_pkg::CLKS_STANDARD;
      if (finish) begin
        unique case (cmd_reg)
          ficu_pkg::CMD_CHIP_ERASE: begin
            PAGE_UNLOCKED <= '1;
            CHIP_SECURITY <= '1;
            from_zero_reg <= 1'b1;
            user_vec_n_reg <= 1'b1;
            vector_reg <= ficu_pkg::FACTORY_VECTOR;
          end
          ficu_pkg::CMD_PART0_ERASE: begin
            PAGE_UNLOCKED[3:0] <= 4'hF;
          end
          ficu_pkg::CMD_PAGE_SECURE: begin
            PAGE_UNLOCKED[sel_reg[2:0]] <= 1'b0;
          end
          ficu_pkg::CMD_CHIP_SECURE: begin
            CHIP_SECURITY[sel_reg[1:0]] <= 1'b0;
          end
          ficu_pkg::CMD_BOOT_OPTION: begin
            if (sel_reg == ficu_pkg::SEL_CLOCK_DOUBLE) begin
              CLOCK_DOUBLE <= 1'b1;
            end
            if (sel_reg == ficu_pkg::SEL_USER_VECTOR) begin
              user_vec_n_reg <= 1'b0;
            end
            if (sel_reg == ficu_pkg::SEL_FROM_ZERO) begin
              from_zero_reg <= 1'b0;
            end
          end
          ficu_pkg::CMD_SET_VECTOR: begin
            vector_reg <= vector_reg & data_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // boot selection once the synchronised pins have settled after reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_reg <= 2'h0;
      BOOT_VALID <= 1'b0;
      BOOT_PC <= ficu_pkg::ZERO_BOOT_PC;
      HW_ENTRY_BOOT <= 1'b0;
      LOADER_ACCESS_EN <= 1'b0;
    end else if (!BOOT_VALID) begin
      if (settle_reg != ficu_pkg::BOOT_SETTLE) begin
        settle_reg <= settle_reg + 2'h1;
      end else begin
        BOOT_VALID <= 1'b1;
        HW_ENTRY_BOOT <= !strap_a_sync && !strap_b_sync;
        LOADER_ACCESS_EN <= from_zero_reg ||
                            (!strap_a_sync && !strap_b_sync && ea_n_sync);
        if (!strap_a_sync && !strap_b_sync) begin
          BOOT_PC <= user_vec_n_reg ? ficu_pkg::DEFAULT_BOOT_PC
                                    : {vector_reg, ficu_pkg::BOOT_PC_LOW};
        end else if (!from_zero_reg) begin
          BOOT_PC <= ficu_pkg::ZERO_BOOT_PC;
        end else if (user_vec_n_reg) begin
          BOOT_PC <= ficu_pkg::DEFAULT_BOOT_PC;
        end else begin
          BOOT_PC <= {vector_reg, ficu_pkg::BOOT_PC_LOW};
        end
      end
    end else if (LOADER_EN_WR) begin
      LOADER_ACCESS_EN <= LOADER_EN_WDATA;
    end
  end

endmodule
`default_nettype wire

/* File: ficu_chk.sv */
/*
  ficu_chk: port-level assertions for the flash command sequencer.
  Assumes it is bound to ficu_top, one clock and an async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ficu_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic IAP_MODE,
  input wire logic CMD_WR,
  input wire logic [7:0] FLASH_DATA_IN,
  input wire logic ARRAY_DONE,
  input wire logic [7:0] ARRAY_RDATA,
  input wire logic ARRAY_START,
  input wire logic [2:0] ARRAY_OP,
  input wire logic [7:0] ARRAY_WDATA,
  input wire logic CPU_HOLD,
  input wire logic CMD_DONE,
  input wire logic CMD_REFUSED,
  input wire logic [7:0] FLASH_DATA_OUT,
  input wire logic FLASH_DATA_LOAD,
  input wire logic [4:0] PAGE_UNLOCKED,
  input wire logic CLOCK_DOUBLE,
  input wire logic [3:0] CLKS_PER_CYCLE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // steps of an array command coming to its end
  sequence s_array_end;
    CPU_HOLD && ARRAY_DONE;
  endsequence
  sequence s_released;
    CMD_DONE && !CPU_HOLD;
  endsequence
  // command acceptance and refusal
  iap_refuse_a: assert property (CMD_WR && !IAP_MODE |=> CMD_REFUSED)
    else $error("command taken outside in-app mode");
  hold_cause_a: assert property ($rose(CPU_HOLD) |-> $past(CMD_WR) && $past(IAP_MODE))
    else $error("hold raised without a command write");
  // hold spans the whole operation
  start_hold_a: assert property (ARRAY_START |-> CPU_HOLD)
    else $error("array started without holding the cpu");
  array_finish_a: assert property (s_array_end |=> s_released)
    else $error("array done not followed by release");
  done_release_a: assert property (CMD_DONE |-> !CPU_HOLD && $past(CPU_HOLD))
    else $error("done without a preceding hold");
  // data paths
  verify_load_a: assert property (FLASH_DATA_LOAD |-> FLASH_DATA_OUT == $past(ARRAY_RDATA))
    else $error("verify data differs from array data");
  program_data_a: assert property (ARRAY_START && ARRAY_OP == 3'h4
    |-> ARRAY_WDATA == $past(FLASH_DATA_IN))
    else $error("program data differs from data register");
  // page bits change only at the end of a command; clocks per cycle follow clock double
  lock_change_a: assert property (PAGE_UNLOCKED != $past(PAGE_UNLOCKED)
    |-> $past(CPU_HOLD))
    else $error("page security changed outside a command");
  clks_follow_a: assert property (CLKS_PER_CYCLE ==
    ($past(CLOCK_DOUBLE) ? ficu_pkg::CLKS_DOUBLED : ficu_pkg::CLKS_STANDARD))
    else $error("clocks per cycle does not follow clock double");
endmodule
bind ficu_top ficu_chk u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .IAP_MODE(IAP_MODE), .CMD_WR(CMD_WR),
  .FLASH_DATA_IN(FLASH_DATA_IN), .ARRAY_DONE(ARRAY_DONE), .ARRAY_RDATA(ARRAY_RDATA),
  .ARRAY_START(ARRAY_START), .ARRAY_OP(ARRAY_OP), .ARRAY_WDATA(ARRAY_WDATA),
  .CPU_HOLD(CPU_HOLD), .CMD_DONE(CMD_DONE), .CMD_REFUSED(CMD_REFUSED),
  .FLASH_DATA_OUT(FLASH_DATA_OUT), .FLASH_DATA_LOAD(FLASH_DATA_LOAD),
  .PAGE_UNLOCKED(PAGE_UNLOCKED), .CLOCK_DOUBLE(CLOCK_DOUBLE), .CLKS_PER_CYCLE(CLKS_PER_CYCLE)
);
`default_nettype wire

/* File: ficu_top_tb.sv */
/*
  ficu_top_tb: self-checking bench for the flash command sequencer.
  Assumes ficu_pkg and ficu_top are compiled first; the bench plays cpu and array.
*/
`timescale 1ns/1ps
`default_nettype none
module ficu_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0, in_app_flash_update = 1'b1, f1 = 1'b0, f2 = 1'b0, cwr = 1'b0, ea_n = 1'b1;
  logic sa = 1'b1, sb = 1'b1, lwr = 1'b0, lwd = 1'b0, adone = 1'b0;
  logic [7:0] wd = 8'h00, ahi = 8'h00, alo = 8'h00, din = 8'h00, ard = 8'h00;
  logic [7:0] rd_val = 8'h3C;
  logic astart, apart, hold, cdone, cref, fload, cdbl, bvalid, lacc, hwe;
  logic [2:0] aop, op_seen;
  logic [14:0] aaddr, addr_seen;
  logic [7:0] awd, fdo, wd_seen;
  logic [4:0] pul;
  logic [3:0] csec, clks;
  logic [15:0] bpc;
  logic part_seen;
  int miscompares = 0, checks_done = 0, cyc = 0, dly = 0, i;
  logic [7:0] codes [4] = '{8'h0E, 8'h0C, 8'h0B, 8'h0D};
  logic [2:0] ops [4] = '{3'h4, 3'h5, 3'h3, 3'h2};

  ficu_top u_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .IAP_MODE(in_app_flash_update), .FEED_FIRST_WR(f1),
    .FEED_SECOND_WR(f2), .CMD_WR(cwr), .SFR_WDATA(wd), .FLASH_ADDR_HIGH(ahi),
    .FLASH_ADDR_LOW(alo), .FLASH_DATA_IN(din), .EXTERNAL_ACCESS_N(ea_n),
    .BOOT_STRAP_PIN_A(sa), .BOOT_STRAP_PIN_B(sb), .LOADER_EN_WR(lwr),
    .LOADER_EN_WDATA(lwd), .ARRAY_DONE(adone), .ARRAY_RDATA(ard), .ARRAY_START(astart),
    .ARRAY_OP(aop), .ARRAY_PART(apart), .ARRAY_ADDR(aaddr), .ARRAY_WDATA(awd),
    .CPU_HOLD(hold), .CMD_DONE(cdone), .CMD_REFUSED(cref), .FLASH_DATA_OUT(fdo),
    .FLASH_DATA_LOAD(fload), .PAGE_UNLOCKED(pul), .CHIP_SECURITY(csec),
    .CLOCK_DOUBLE(cdbl), .CLKS_PER_CYCLE(clks), .BOOT_PC(bpc), .BOOT_VALID(bvalid),
    .LOADER_ACCESS_EN(lacc), .HW_ENTRY_BOOT(hwe)
  );

  always #20 ref_clk = ~ref_clk;

  // array stand-in: done three edges after start, data then scrambled
  always @(posedge ref_clk) begin
    adone <= 1'b0;
    if (astart) dly <= 3;
    else if (dly == 1) begin
      dly <= 0;
      adone <= 1'b1;
      ard <= rd_val;
    end else if (dly > 1) dly <= dly - 1;
    else ard <= ~rd_val;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // reset with given strap levels, then wait out the boot decision
  task automatic do_reset(input logic a, input logic b);
    @(posedge ref_clk);
    sa <= a;
    sb <= b;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    check("boot_valid", bvalid, 1'b1);
  endtask

  // one-cycle strobe: 0 first feed, 1 second feed, 2 command
  task automatic put(input int which, input logic [7:0] v);
    @(posedge ref_clk);
    wd <= v;
    f1 <= (which == 0);
    f2 <= (which == 1);
    cwr <= (which == 2);
    @(posedge ref_clk);
    f1 <= 1'b0;
    f2 <= 1'b0;
    cwr <= 1'b0;
  endtask

  // feed (key 00 skips it), command, wait for done or refusal
  task automatic issue(input logic [7:0] key, input logic [7:0] code, input logic [7:0] hi,
                       input logic ok);
    int n;
    @(posedge ref_clk);
    ahi <= hi;
    alo <= 8'h34;
    if (key != 8'h00) begin
      put(0, ficu_pkg::FEED_FIRST_KEY);
      put(1, key);
    end
    put(2, code);
    for (n = 0; n < 20; n++) begin
      #1;
      if (astart === 1'b1) begin
        op_seen = aop;
        part_seen = apart;
        addr_seen = aaddr;
        wd_seen = awd;
      end
      if (cdone === 1'b1 || cref === 1'b1) break;
      @(posedge ref_clk);
    end
    check("done", cdone, ok);
    check("refused", cref, !ok);
    // return on an edge so callers change inputs there
    @(posedge ref_clk);
  endtask

  initial begin
    do_reset(1'b1, 1'b1);
    check("page_bits", pul, 5'h1F);
    check("chip_bits", csec, 4'hF);
    check("clks", clks, 4'hC);
    check("boot_pc", bpc, 16'hF800);
    check("hw_entry", hwe, 1'b0);
    check("loader", lacc, 1'b1);
    issue(8'h00, 8'h0E, 8'h12, 1'b0);
    @(posedge ref_clk);
    in_app_flash_update <= 1'b0;
    din <= 8'hA5;
    issue(ficu_pkg::FEED_PART0_KEY, 8'h0E, 8'h12, 1'b0);
    in_app_flash_update <= 1'b1;
    // program, verify, sector and partition-0 erase on an erased array away from fetched code
    for (i = 0; i < 4; i++) begin
      issue(ficu_pkg::FEED_PART0_KEY, codes[i], 8'h12, 1'b1);
      check("op", op_seen, ops[i]);
      check("addr", addr_seen, 15'h1234);
      check("part", part_seen, 1'b0);
      if (i == 0) check("wdata", wd_seen, 8'hA5);
    end
    issue(8'h00, 8'h0E, 8'h12, 1'b0);
    issue(ficu_pkg::FEED_PART1_KEY, 8'h0C, 8'h05, 1'b1);
    check("verify", fdo, rd_val);
    check("part1", part_seen, 1'b1);
    // lock page 1, refuse a write there, erase partition 0 to unlock
    issue(ficu_pkg::FEED_PART0_KEY, 8'h03, 8'h91, 1'b1);
    check("page_bits", pul, 5'h1D);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h0E, 8'h20, 1'b0);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h0D, 8'h00, 1'b1);
    check("page_bits", pul, 5'h1F);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h08, 8'hE0, 1'b1);
    check("clk_double", cdbl, 1'b1);
    @(posedge ref_clk);
    #1;
    check("clks", clks, 4'h6);
    // chip erase refused from internal execution, then clears all locks
    issue(ficu_pkg::FEED_PART0_KEY, 8'h03, 8'h94, 1'b1);
    check("page_bits", pul, 5'h0F);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h05, 8'hB0, 1'b1);
    check("chip_bits", csec, 4'hE);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h01, 8'h00, 1'b0);
    ea_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    issue(ficu_pkg::FEED_PART0_KEY, 8'h01, 8'h00, 1'b1);
    check("op", op_seen, 3'h1);
    check("page_bits", pul, 5'h1F);
    check("chip_bits", csec, 4'hF);
    ea_n <= 1'b1;
    // strap entry boot, then software clears loader access
    do_reset(1'b0, 1'b0);
    check("hw_entry", hwe, 1'b1);
    check("boot_pc", bpc, 16'hF800);
    check("loader", lacc, 1'b1);
    @(posedge ref_clk);
    lwr <= 1'b1;
    @(posedge ref_clk);
    lwr <= 1'b0;
    #1;
    check("loader", lacc, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
